// [verilog/pat_consts.svh]
`ifndef PAT_CONSTS_SVH
`define PAT_CONSTS_SVH

// address and table geometry
`define PAT_AW 32
`define PAT_TBL_AW 8
`define PAT_TBL_DEPTH 256
// logical address split
`define PAT_A_MSB 31
`define PAT_A_LSB 25
`define PAT_B_MSB 24
`define PAT_B_LSB 18
`define PAT_C_MSB 17
`define PAT_C4_LSB 12
`define PAT_C8_LSB 13
// page offset widths
`define PAT_OFS4_W 12
`define PAT_OFS8_W 13
// descriptor fields
`define PAT_DESC_RESIDENT 0
`define PAT_DESC_SUPER 2
`define PAT_DESC_BASE_LSB 12
// page size codes
`define PAT_PAGE_4K 1'b0
`define PAT_PAGE_8K 1'b1
// reset values
`define PAT_ADDR_RESET 32'h0000_0000
`define PAT_BASE_RESET 8'h00

`endif

// [verilog/pat_pkg.sv]
`include "pat_consts.svh"

package pat_pkg;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [2:0] {
      st_idle,
      st_level_a,
      st_level_b,
      st_level_c
   } walk_state_type;

   typedef logic [`PAT_AW-1:0] addr_type;
   typedef logic [`PAT_TBL_AW-1:0] tbl_addr_type;

   typedef struct packed {
      walk_state_type state;
      addr_type la;          // logical address under walk
      logic sup;             // privilege of the access
      logic sup_only;        // supervisor bits ORed along the walk
      logic big_page;        // page size latched with the request
      tbl_addr_type tbase;   // base of the next table
      logic dis_meta;        // disable pin, first stage
      logic dis_sync;        // disable pin, second stage
      addr_type addr_out;
      logic fault;
      logic ack;
      logic ready;
   } gate_state_type;

endpackage

// [verilog/paged_address_translation_gate.sv]
`include "pat_consts.svh"

module paged_address_translation_gate (
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic translation_disable_n,
   input wire logic translation_enable,
   input wire logic page_size_8k,
   input wire pat_pkg::tbl_addr_type supervisor_table_root,
   input wire pat_pkg::tbl_addr_type user_table_root,
   input wire logic tbl_we,
   input wire pat_pkg::tbl_addr_type tbl_waddr,
   input wire logic [31:0] tbl_wdata,
   input wire logic req,
   input wire pat_pkg::addr_type logical_addr,
   input wire logic supervisor,
   output logic req_ready,
   output pat_pkg::addr_type phys_addr,
   output logic ack,
   output logic fault
);
   import pat_pkg::*;

   // ----------------------------------------
   // storage
   // ----------------------------------------
   gate_state_type cur;
   gate_state_type next_cur;
   logic [31:0] table_mem [0:`PAT_TBL_DEPTH-1];
   logic [31:0] desc;
   logic xlate_on;
   logic [6:0] idx_c;
   logic sup_seen;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // table slot from base plus index, wraps inside the table store
   function automatic tbl_addr_type tbl_index(input tbl_addr_type base,
                                               input logic [6:0] idx);
      logic [`PAT_TBL_AW:0] sum;
      sum = {1'b0, base} + {2'b00, idx};
      return sum[`PAT_TBL_AW-1:0];
   endfunction

   // next table base taken from a descriptor
   function automatic tbl_addr_type desc_base(input logic [31:0] d);
      return d[`PAT_DESC_BASE_LSB +: `PAT_TBL_AW];
   endfunction

   // end the walk with a fault; the bus keeps its last good address
   function automatic gate_state_type walk_abort(input gate_state_type s);
      gate_state_type r;
      r = s;
      r.state = st_idle;
      r.ready = 1'b1;
      r.fault = 1'b1;
      r.ack = 1'b1;
      return r;
   endfunction

   // physical frame from a level C descriptor plus the page offset
   function automatic addr_type frame_join(input logic [31:0] d,
                                           input addr_type la,
                                           input logic big);
      addr_type pa;
      if (big == `PAT_PAGE_8K) begin
         pa = {d[31:`PAT_OFS8_W], la[`PAT_OFS8_W-1:0]};
      end else begin
         pa = {d[31:`PAT_OFS4_W], la[`PAT_OFS4_W-1:0]};
      end
      return pa;
   endfunction

   // ----------------------------------------
   // table store
   // ----------------------------------------
   // software loads descriptors; tables may change between walks
   always_ff @(posedge clk) begin
      if (ce && tbl_we) begin
         table_mem[tbl_waddr] <= tbl_wdata;
      end
   end

   // level C index width depends on the page size
   always_comb begin
      if (cur.big_page == `PAT_PAGE_8K) begin
         idx_c = {2'b00, cur.la[`PAT_C_MSB:`PAT_C8_LSB]};
      end else begin
         idx_c = {1'b0, cur.la[`PAT_C_MSB:`PAT_C4_LSB]};
      end
   end

   // descriptor read for the level under walk
   always_comb begin
      desc = 32'h0000_0000;
      unique case (cur.state)
         st_idle: desc = 32'h0000_0000;
         st_level_a: desc = table_mem[tbl_index(cur.tbase, cur.la[`PAT_A_MSB:`PAT_A_LSB])];
         st_level_b: desc = table_mem[tbl_index(cur.tbase, cur.la[`PAT_B_MSB:`PAT_B_LSB])];
         st_level_c: desc = table_mem[tbl_index(cur.tbase, idx_c)];
      endcase
   end

   // both the synced pin and the software bit must allow it
   assign xlate_on = cur.dis_sync && translation_enable;

   // supervisor-only marks OR together down the walk
   assign sup_seen = cur.sup_only | desc[`PAT_DESC_SUPER];

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_cur = cur;
      next_cur.ack = 1'b0;
      // pin comes from outside, two flops before use
      next_cur.dis_meta = translation_disable_n;
      next_cur.dis_sync = cur.dis_meta;
      unique case (cur.state)
         st_idle: begin
            if (req) begin
               if (!xlate_on) begin
                  // untranslated, straight to the bus
                  next_cur.addr_out = logical_addr;
                  next_cur.fault = 1'b0;
                  next_cur.ack = 1'b1;
               end else begin
                  next_cur.state = st_level_a;
                  next_cur.ready = 1'b0;
                  next_cur.la = logical_addr;
                  next_cur.sup = supervisor;
                  next_cur.sup_only = 1'b0;
                  next_cur.big_page = page_size_8k;
                  // root by privilege of this access
                  next_cur.tbase = supervisor ? supervisor_table_root
                                              : user_table_root;
               end
            end
         end
         st_level_a: begin
            next_cur.sup_only = sup_seen;
            next_cur.tbase = desc_base(desc);
            if (!desc[`PAT_DESC_RESIDENT]) begin
               next_cur = walk_abort(next_cur);
            end else begin
               next_cur.state = st_level_b;
            end
         end
         st_level_b: begin
            next_cur.sup_only = sup_seen;
            next_cur.tbase = desc_base(desc);
            if (!desc[`PAT_DESC_RESIDENT]) begin
               next_cur = walk_abort(next_cur);
            end else begin
               next_cur.state = st_level_c;
            end
         end
         st_level_c: begin
            next_cur.sup_only = sup_seen;
            if (!desc[`PAT_DESC_RESIDENT]) begin
               // missing page: abort
               next_cur = walk_abort(next_cur);
            end else if (!cur.sup && sup_seen) begin
               // user touching supervisor page: blocked, no address
               next_cur = walk_abort(next_cur);
            end else begin
               // frame plus page offset onto the bus
               next_cur.state = st_idle;
               next_cur.ready = 1'b1;
               next_cur.ack = 1'b1;
               next_cur.fault = 1'b0;
               next_cur.addr_out = frame_join(desc, cur.la, cur.big_page);
            end
         end
      endcase
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         cur.state <= st_idle;
         cur.la <= `PAT_ADDR_RESET;
         cur.sup <= 1'b0;
         cur.sup_only <= 1'b0;
         cur.big_page <= `PAT_PAGE_4K;
         cur.tbase <= `PAT_BASE_RESET;
         cur.dis_meta <= 1'b0;   // treated as asserted until sampled
         cur.dis_sync <= 1'b0;
         cur.addr_out <= `PAT_ADDR_RESET;
         cur.fault <= 1'b0;
         cur.ack <= 1'b0;
         cur.ready <= 1'b1;
      end else if (ce) begin
         cur <= next_cur;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign req_ready = cur.ready;
   assign phys_addr = cur.addr_out;
   assign ack = cur.ack;
   assign fault = cur.fault;

endmodule

// [test/pat_checker.sv]
module pat_checker (
   input wire logic clk,
   input wire logic reset,
   input wire logic translation_disable_n,
   input wire logic translation_enable,
   input wire logic req,
   input wire pat_pkg::addr_type logical_addr,
   input wire logic req_ready,
   input wire pat_pkg::addr_type phys_addr,
   input wire logic ack,
   input wire logic fault
);
   timeunit 1ns;
   timeprecision 1ps;
   import pat_pkg::*;
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   // ------------------------------
   // port timing checks
   // ------------------------------
   // a second answer at once needs a request taken in the answer cycle
   a_ack_one_pulse: assert property (
      ack && !req |=> !ack) else $error("ack too long");
   a_ack_has_cause: assert property (
      ack |-> $past(req && req_ready) || !$past(req_ready)) else $error("ack without request");
   a_pass_addr: assert property (
      req && req_ready && !translation_enable |=>
         ack && !fault && phys_addr == $past(logical_addr)) else $error("no pass");
   a_pin_veto: assert property (
      !translation_disable_n [*3] ##0 (req && req_ready) |=>
         ack && phys_addr == $past(logical_addr)) else $error("pin veto lost");
   a_take_answer: assert property (
      req && req_ready |-> ##[1:4] ack) else $error("no answer");
   a_walk_bound: assert property (
      $fell(req_ready) |-> ##[1:3] ack) else $error("walk too long");
   a_ack_idle: assert property (ack |-> req_ready) else $error("busy at ack");
   a_fault_keeps: assert property (
      ack && fault |-> $stable(phys_addr)) else $error("fault moved address");
   // main scenarios
   cover property (ack && fault);
   cover property (ack && !fault && $past(!req_ready));
   cover property (req && req_ready && !translation_enable);
endmodule

// [test/core_model.sv]
module core_model (
   input wire logic clk,
   input wire logic go,
   input wire pat_pkg::addr_type go_addr,
   input wire logic go_sup,
   input wire logic req_ready,
   output logic req,
   output pat_pkg::addr_type logical_addr,
   output logic supervisor
);
   timeunit 1ns;
   timeprecision 1ps;
   import pat_pkg::*;
   // ------------------------------
   // request held until taken
   // ------------------------------
   initial begin
      req = 1'b0;
      logical_addr = 32'h0000_0000;
      supervisor = 1'b0;
   end
   always @(posedge clk) begin
      if (go) begin
         req <= 1'b1;
         logical_addr <= go_addr;
         supervisor <= go_sup;
      end else if (req && req_ready) begin
         req <= 1'b0;
         logical_addr <= ~logical_addr; // released bus shows no stale value
         supervisor <= ~supervisor;
      end
   end
endmodule

// [test/testbench.sv]
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import pat_pkg::*;
   logic clk, reset, pin_n, en, big, tbl_we, go, go_sup, req, sup, req_ready, ack, fault;
   tbl_addr_type tbl_waddr;
   logic [31:0] tbl_wdata;
   addr_type go_addr, la, phys;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;
   // slot and descriptor pairs
   logic [39:0] tbl [10] = '{40'h00_0001_0001, 40'h10_0002_0001, 40'h24_ABCD_E001,
      40'h22_1234_6001, 40'h80_0009_0001, 40'h90_000A_0001, 40'hA4_5555_5001,
      40'h81_0009_0005, 40'hA0_7777_7001, 40'h82_0000_0000};
   // ------------------------------
   // models and tasks
   // ------------------------------
   paged_address_translation_gate DUT (.clk(clk), .reset(reset), .ce(1'b1),
      .translation_disable_n(pin_n), .translation_enable(en), .page_size_8k(big),
      .supervisor_table_root(8'h00), .user_table_root(8'h80), .tbl_we(tbl_we),
      .tbl_waddr(tbl_waddr), .tbl_wdata(tbl_wdata), .req(req), .logical_addr(la),
      .supervisor(sup), .req_ready(req_ready), .phys_addr(phys), .ack(ack), .fault(fault));
   core_model core (.clk(clk), .go(go), .go_addr(go_addr), .go_sup(go_sup),
      .req_ready(req_ready), .req(req), .logical_addr(la), .supervisor(sup));
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         bad_count++;
         end_sim;
      end
   end
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task access(input addr_type a, input logic s, input addr_type exp, input logic f);
      int n;
      go <= 1'b1;
      go_addr <= a;
      go_sup <= s;
      @(posedge clk);
      go <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      check("ack", {31'h0, ack}, 32'h1);
      check("phys_addr", phys, exp);
      check("fault", {31'h0, fault}, {31'h0, f});
      @(posedge clk);
   endtask
   task end_sim;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ------------------------------
   // sequence
   // ------------------------------
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      pin_n = 1'b0;
      {en, big, tbl_we, go, go_sup} = 5'h00;
      tbl_waddr = 8'h00;
      tbl_wdata = 32'h0000_0000;
      go_addr = 32'h0000_0000;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         tbl_we <= 1'b1;
         {tbl_waddr, tbl_wdata} <= tbl[i];
         @(posedge clk);
      end
      tbl_we <= 1'b0;
      access(32'h1234_5678, 1'b1, 32'h1234_5678, 1'b0);
      en <= 1'b1;
      access(32'h0000_40F8, 1'b1, 32'h0000_40F8, 1'b0);
      pin_n <= 1'b1;
      repeat (3) @(posedge clk);
      access(32'h0000_40F8, 1'b1, 32'hABCD_E0F8, 1'b0);
      access(32'h0000_40F8, 1'b0, 32'h5555_50F8, 1'b0);
      big <= 1'b1;
      access(32'h0000_40F8, 1'b1, 32'h1234_60F8, 1'b0);
      big <= 1'b0;
      access(32'h0200_0000, 1'b0, 32'h1234_60F8, 1'b1);
      access(32'h0400_0000, 1'b0, 32'h1234_60F8, 1'b1);
      // agent remaps a page for a moment, then puts it back
      tbl_we <= 1'b1;
      {tbl_waddr, tbl_wdata} <= 40'h24_2468_A001;
      @(posedge clk);
      tbl_we <= 1'b0;
      access(32'h0000_40F8, 1'b1, 32'h2468_A0F8, 1'b0);
      tbl_we <= 1'b1;
      {tbl_waddr, tbl_wdata} <= tbl[2];
      @(posedge clk);
      tbl_we <= 1'b0;
      access(32'h0000_40F8, 1'b1, 32'hABCD_E0F8, 1'b0);
      end_sim;
   end
endmodule

bind paged_address_translation_gate pat_checker chk (.clk(clk), .reset(reset),
   .translation_disable_n(translation_disable_n), .translation_enable(translation_enable),
   .req(req), .logical_addr(logical_addr), .req_ready(req_ready), .phys_addr(phys_addr),
   .ack(ack), .fault(fault));
